/* inc/fwpr_pkg.sv */
// Constants shared by the flash write-protect and reset control block.
package fwpr_pkg;
   // Instruction codes seen on the decoded instruction port.
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_RDSR1 = 8'h05;
   localparam logic [7:0] OP_RDSR2 = 8'h35;
   localparam logic [7:0] OP_RDSR3 = 8'h15;
   localparam logic [7:0] OP_PP = 8'h02;
   localparam logic [7:0] OP_QPP = 8'h32;
   localparam logic [7:0] OP_SE = 8'h20;
   localparam logic [7:0] OP_BE32 = 8'h52;
   localparam logic [7:0] OP_BE64 = 8'hd8;
   localparam logic [7:0] OP_CE1 = 8'hc7;
   localparam logic [7:0] OP_CE2 = 8'h60;
   localparam logic [7:0] OP_SECR_ER = 8'h44;
   localparam logic [7:0] OP_SECR_PG = 8'h42;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_PDOWN = 8'hb9;
   localparam logic [7:0] OP_RELEASE = 8'hab;
   localparam logic [7:0] OP_RST_EN = 8'h66;
   localparam logic [7:0] OP_RST = 8'h99;
   localparam logic [7:0] OP_UNLOCK = 8'h39;
   localparam logic [7:0] OP_LOCK = 8'h36;
   // Status bit positions in the 24-bit status word.
   localparam int BIT_BUSY = 0;
   localparam int BIT_WEL = 1;
   localparam int BIT_RANGE_LO = 2;
   localparam int BIT_TB = 5;
   localparam int BIT_SEC = 6;
   localparam int BIT_SRP = 7;
   localparam int BIT_SRL = 8;
   localparam int BIT_CMP = 14;
   localparam int BIT_WPS = 18;
   // Values after power-on for the protection fields.
   localparam logic [2:0] RANGE_RST = 3'h0;
   localparam logic TB_RST = 1'b0;
   localparam logic SEC_RST = 1'b0;
   localparam logic CMP_RST = 1'b0;
   localparam logic WPS_RST = 1'b0;
   // Lock bit array: 62 inner blocks plus 32 edge sectors.
   localparam int NUM_LOCKS = 94;
   localparam int EDGE_SECTORS = 16;
   // Array size in bytes; protected ranges are measured from either end of it.
   localparam logic [24:0] ARRAY_BYTES = 25'h0400000;
   // Timing.
   localparam int CLK_MHZ = 125;
   localparam int TRST_US = 30;
   localparam int TRST_CYCLES = TRST_US * CLK_MHZ;
   localparam int TPIN_US = 1;
   localparam int TPIN_CYCLES = TPIN_US * CLK_MHZ;
   // Control states.
   typedef enum logic [3:0] {
      ST_READY = 4'h1,
      ST_BUSY = 4'h2,
      ST_PDOWN = 4'h4,
      ST_RESET = 4'h8
   } fwpr_state_e;
endpackage

/* hw/fwpr_ctrl.sv */
// Write-protect, write-enable, busy and reset control for a serial flash.
// What this block does
// - Soft reset needs 66h then 99h back to back.
// - Reset takes 30us; all instructions rejected meanwhile.
// - Reset pin low 1us aborts, clears latch, sets all locks.
// - Reset pin overrides all serial activity.
// - Supply low holds reset, no instructions recognised.
// - Write-class instructions rejected until power-up delay ends.
// - Program, erase, status write need latch set.
// - Write enable latch at S1, set by 06h.
// - Latch cleared at power-up and by write ops.
// - Power-down accepts only release instruction.
// - 62 block locks and 32 edge sector locks.
// - Lock scheme ignores ops on locked regions.
// - Locks all set at power-on; 39h unlocks one.
// - Scheme select picks range fields or lock bits.
// - Busy at S0 while operation runs, then clears.
// - Busy accepts only status reads and suspend.
// - Range field at S4..S2, status-writable, default zero.
// - Top/bottom bit: zero top, one bottom.
// - Sector bit: one 4KB units, zero 64KB.
// - Complement bit at S14 inverts the region.
// - Status write needs latch and lock bits permitting.
// - Pin guard with low protect pin blocks status writes.
module fwpr_ctrl
   import fwpr_pkg::*;
#(
   parameter int PUW_CYCLES = 1250
)
(
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Device pins and supply monitor.
   input wire logic reset_pin_n_i,
   input wire logic supply_low_i,
   input wire logic write_protect_n_i,
   // Decoded instructions from the serial front end.
   input wire logic instr_valid_i,
   input wire logic [7:0] instr_code_i,
   input wire logic [23:0] instr_addr_i,
   input wire logic [23:0] instr_data_i,
   output logic instr_accept_o,
   output logic instr_reject_o,
   // Program and erase engine.
   output logic op_start_o,
   output logic [7:0] op_code_o,
   output logic [23:0] op_addr_o,
   output logic op_abort_o,
   input wire logic op_done_i,
   // Status registers.
   output logic [7:0] protect_status_low_o,
   output logic [7:0] protect_status_mid_o,
   output logic protection_scheme_select_o
);

   // Range hit for the field-based scheme, inversion applied.
   function automatic logic range_hit(input logic [23:0] a, input logic [2:0] r,
                                      input logic tb, input logic sec, input logic inv);
      logic [4:0] sh;
      logic [24:0] sz;
      logic hit;
      sh = 5'h0;
      sz = 25'h0;
      hit = 1'b0;
      if (r == 3'h7)
         hit = 1'b1;
      else if (r != 3'h0)
      begin
         sh = sec ? ((r > 3'h4) ? 5'hf : 5'(5'hb + 5'(r))) : 5'(5'hf + 5'(r));
         sz = 25'h1 << sh;
         hit = tb ? ({3'h0, a[21:0]} < sz) : ({3'h0, a[21:0]} >= (ARRAY_BYTES - sz));
      end
      return hit ^ inv;
   endfunction

   // Lock bit index: edge sectors first, then inner blocks.
   function automatic logic [6:0] lock_idx(input logic [23:0] a);
      logic [6:0] i;
      i = 7'h0;
      if (a[21:16] == 6'h00)
         i = {3'h0, a[15:12]};
      else if (a[21:16] == 6'h3f)
         i = 7'(EDGE_SECTORS) + {3'h0, a[15:12]};
      else
         i = 7'(2 * EDGE_SECTORS) + {1'b0, a[21:16]} - 7'h1;
      return i;
   endfunction

   fwpr_state_e state_q;
   logic wel_q, rst_en_q, srp_q, srl_q, tb_q, sec_q, cmp_q, wps_q;
   logic [2:0] range_q;
   logic [NUM_LOCKS-1:0] lock_q;
   logic [11:0] rst_cnt_q;
   logic [7:0] pin_cnt_q;
   logic [$clog2(PUW_CYCLES+1)-1:0] puw_cnt_q;
   logic hw_hold, pin_abort, write_class, array_op, status_rd;
   logic prot, accept, wr_ok, soft_rst;

   // A reset pin low for the full time, or a low supply, forces the reset state.
   assign pin_abort = (pin_cnt_q == 8'(TPIN_CYCLES - 1)) && !reset_pin_n_i;
   assign hw_hold = supply_low_i || !reset_pin_n_i;

   // Instruction classes.
   always_comb
   begin
      array_op = instr_code_i inside {OP_PP, OP_QPP, OP_SE, OP_BE32, OP_BE64,
                                      OP_CE1, OP_CE2, OP_SECR_ER, OP_SECR_PG};
      write_class = array_op || instr_code_i inside {OP_WREN, OP_WRSR};
      status_rd = instr_code_i inside {OP_RDSR1, OP_RDSR2, OP_RDSR3};
   end

   // Protection check: security register ops pass; otherwise the scheme bit picks exactly one source.
   always_comb
   begin
      if (instr_code_i inside {OP_SECR_ER, OP_SECR_PG})
         prot = 1'b0;
      else if (instr_code_i inside {OP_CE1, OP_CE2})
         prot = wps_q ? |lock_q : (cmp_q || range_q != 3'h0);
      else if (wps_q)
         prot = lock_q[lock_idx(instr_addr_i)];
      else
         prot = range_hit(instr_addr_i, range_q, tb_q, sec_q, cmp_q);
   end

   // Status write permission follows the latch and the two guard bits.
   assign wr_ok = wel_q && !srl_q && !(srp_q && !write_protect_n_i);

   // Acceptance decision for the instruction in this cycle.
   always_comb
   begin
      accept = 1'b0;
      if (instr_valid_i && !hw_hold)
      begin
         case (state_q)
            ST_RESET: accept = 1'b0;
            ST_PDOWN: accept = (instr_code_i == OP_RELEASE);
            ST_BUSY: accept = status_rd || (instr_code_i == OP_SUSPEND);
            ST_READY:
            begin
               if (write_class && puw_cnt_q != '0)
                  accept = 1'b0;
               else if (array_op)
                  accept = wel_q && !prot;
               else if (instr_code_i == OP_WRSR)
                  accept = wr_ok;
               else if (instr_code_i == OP_RST)
                  accept = rst_en_q;
               else
                  accept = 1'b1;
            end
            default: accept = 1'b0;
         endcase
      end
   end
   assign soft_rst = accept && instr_code_i == OP_RST && state_q == ST_READY;

   // Reset pin low-time counter; a shorter pulse only blocks instructions.
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i || reset_pin_n_i)
         pin_cnt_q <= 8'h0;
      else if (!pin_abort)
         pin_cnt_q <= pin_cnt_q + 8'h1;
   end

   // Main control state.
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         state_q <= ST_RESET;
         rst_cnt_q <= 12'h0;
      end
      else if (pin_abort || supply_low_i)
      begin
         state_q <= ST_RESET;
         rst_cnt_q <= 12'h0;
      end
      else
      begin
         case (state_q)
            ST_RESET:
            begin
               if (rst_cnt_q != 12'h0)
                  rst_cnt_q <= rst_cnt_q - 12'h1;
               else if (reset_pin_n_i)
                  state_q <= ST_READY;
            end
            ST_READY:
            begin
               if (soft_rst)
               begin
                  state_q <= ST_RESET;
                  rst_cnt_q <= 12'(TRST_CYCLES - 1);
               end
               else if (accept && (array_op || instr_code_i == OP_WRSR))
                  state_q <= ST_BUSY;
               else if (accept && instr_code_i == OP_PDOWN)
                  state_q <= ST_PDOWN;
            end
            ST_BUSY:
               if (op_done_i)
                  state_q <= ST_READY;
            ST_PDOWN:
               if (accept)
                  state_q <= ST_READY;
            default: state_q <= ST_RESET;
         endcase
      end
   end

   // Power-up write delay restarts after every supply dip or resetn_i reset.
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i || supply_low_i)
         puw_cnt_q <= ($clog2(PUW_CYCLES+1))'(PUW_CYCLES);
      else if (puw_cnt_q != '0)
         puw_cnt_q <= puw_cnt_q - 1'b1;
   end

   // Reset enable is consumed or discarded by the next instruction.
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i || state_q == ST_RESET)
         rst_en_q <= 1'b0;
      else if (instr_valid_i)
         rst_en_q <= accept && instr_code_i == OP_RST_EN;
   end

   // Write enable latch.
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i || state_q == ST_RESET)
         wel_q <= 1'b0;
      else if (accept && state_q == ST_READY)
      begin
         if (instr_code_i == OP_WREN)
            wel_q <= 1'b1;
         else if (array_op || instr_code_i inside {OP_WRDI, OP_WRSR})
            wel_q <= 1'b0;
      end
   end

   // Status fields; these survive a soft reset like non-volatile bits would.
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         range_q <= RANGE_RST;
         tb_q <= TB_RST;
         sec_q <= SEC_RST;
         cmp_q <= CMP_RST;
         wps_q <= WPS_RST;
         srp_q <= 1'b0;
      end
      else if (soft_rst == 1'b0 && accept && state_q == ST_READY && instr_code_i == OP_WRSR)
      begin
         range_q <= instr_data_i[BIT_RANGE_LO +: 3];
         tb_q <= instr_data_i[BIT_TB];
         sec_q <= instr_data_i[BIT_SEC];
         srp_q <= instr_data_i[BIT_SRP];
         cmp_q <= instr_data_i[BIT_CMP];
         wps_q <= instr_data_i[BIT_WPS];
      end
   end

   // Lock-down holds until the supply cycles, so only a supply dip or resetn_i clears it.
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i || supply_low_i)
         srl_q <= 1'b0;
      else if (accept && state_q == ST_READY && instr_code_i == OP_WRSR)
         srl_q <= instr_data_i[BIT_SRL];
   end

   // Per-region lock bits.
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i || state_q == ST_RESET)
         lock_q <= '1;
      else if (accept && state_q == ST_READY && instr_code_i == OP_UNLOCK)
         lock_q[lock_idx(instr_addr_i)] <= 1'b0;
      else if (accept && state_q == ST_READY && instr_code_i == OP_LOCK)
         lock_q[lock_idx(instr_addr_i)] <= 1'b1;
   end

   // Registered answers and engine commands.
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         instr_accept_o <= 1'b0;
         instr_reject_o <= 1'b0;
         op_start_o <= 1'b0;
         op_code_o <= 8'h0;
         op_addr_o <= 24'h0;
         op_abort_o <= 1'b0;
      end
      else
      begin
         instr_accept_o <= accept;
         instr_reject_o <= instr_valid_i && !accept;
         op_start_o <= accept && state_q == ST_READY
                       && (array_op || instr_code_i == OP_WRSR);
         if (accept)
         begin
            op_code_o <= instr_code_i;
            op_addr_o <= instr_addr_i;
         end
         op_abort_o <= pin_abort || supply_low_i || soft_rst;
      end
   end

   // Status outputs are assembled from the held state flops.
   assign protect_status_low_o = {srp_q, sec_q, tb_q, range_q, wel_q, state_q == ST_BUSY};
   assign protect_status_mid_o = {1'b0, cmp_q, 5'h0, srl_q};
   assign protection_scheme_select_o = wps_q;

   busy_clear_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      state_q == ST_BUSY && op_done_i && !hw_hold |=> !protect_status_low_o[BIT_BUSY])
      else $error("busy did not clear after done");
   rst_pair_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      soft_rst |-> rst_en_q && $past(rst_en_q || (instr_valid_i && instr_code_i == OP_RST_EN)))
      else $error("reset taken without enable");
   rst_window_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      soft_rst && !hw_hold ##1 !hw_hold [*8] |-> !instr_accept_o [*8])
      else $error("instruction accepted during reset");
   pin_prio_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !reset_pin_n_i |=> !instr_accept_o)
      else $error("instruction accepted with reset pin low");
   wel_set_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      accept && state_q == ST_READY && instr_code_i == OP_WREN && !hw_hold
      |=> protect_status_low_o[BIT_WEL])
      else $error("latch not set by write enable");
   need_wel_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      op_start_o |-> $past(wel_q))
      else $error("operation started without latch");
   pdown_only_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      state_q == ST_PDOWN && instr_valid_i && instr_code_i != OP_RELEASE
      |=> instr_reject_o)
      else $error("power-down accepted other instruction");
   busy_ignore_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      state_q == ST_BUSY && instr_valid_i && instr_code_i == OP_WREN |=> instr_reject_o)
      else $error("busy accepted write enable");
   puw_block_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      instr_valid_i && write_class && puw_cnt_q != '0 |=> instr_reject_o)
      else $error("write accepted in power-up delay");
   guard_pin_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      instr_valid_i && instr_code_i == OP_WRSR && srp_q && !srl_q && !write_protect_n_i
      |=> instr_reject_o)
      else $error("status write passed low protect pin");

endmodule // fwpr_ctrl

/* test/fwpr_engine_model.sv */
// Behavioural program and erase engine that finishes each started operation that is not aborted.
module fwpr_engine_model
#(
   parameter int DONE_CYCLES = 20
)
(
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Engine handshake.
   input wire logic op_start_i,
   input wire logic op_abort_i,
   output logic op_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_q;
   // Count down a started operation; an abort drops it with no done pulse, so a
   // late done can never clear busy after a reset.
   always_ff @(posedge clk_sys_i)
   begin
      op_done_o <= 1'b0;
      if (!resetn_i || op_abort_i)
      begin
         cnt_q <= 0;
      end
      else if (op_start_i)
      begin
         cnt_q <= DONE_CYCLES;
      end
      else if (cnt_q > 0)
      begin
         cnt_q <= cnt_q - 1;
         op_done_o <= (cnt_q == 1);
      end
   end
endmodule // fwpr_engine_model

/* test/flash_write_protect_reset_test.sv */
// Self-checking bench for the flash write-protect and reset control block.
`define CHK(nm, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         n_errors++; \
         $display("Error %s expected %h seen %h", nm, exp, got); \
      end \
   end
module flash_write_protect_reset_test
   import fwpr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0;
   logic resetn_i, reset_pin_n_i, supply_low_i, write_protect_n_i, instr_valid_i;
   logic [7:0] instr_code_i;
   logic [23:0] instr_addr_i, instr_data_i;
   logic instr_accept_o, instr_reject_o, op_start_o, op_abort_o, op_done_i;
   logic [7:0] op_code_o;
   logic [23:0] op_addr_o;
   logic [7:0] protect_status_low_o, protect_status_mid_o;
   logic protection_scheme_select_o;
   int n_errors = 0;
   int n_tests = 0;
   int n_abort = 0;
   int a0;
   // Clock at 125 MHz.
   always #4 clk_sys_i = ~clk_sys_i;
   // Abort pulses are counted so a short one cannot slip between checks.
   always @(posedge clk_sys_i)
   begin
      if (op_abort_o === 1'b1)
      begin
         n_abort <= n_abort + 1;
      end
   end
   fwpr_ctrl #(.PUW_CYCLES(4)) dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .reset_pin_n_i(reset_pin_n_i), .supply_low_i(supply_low_i),
      .write_protect_n_i(write_protect_n_i), .instr_valid_i(instr_valid_i),
      .instr_code_i(instr_code_i), .instr_addr_i(instr_addr_i), .instr_data_i(instr_data_i),
      .instr_accept_o(instr_accept_o), .instr_reject_o(instr_reject_o),
      .op_start_o(op_start_o), .op_code_o(op_code_o), .op_addr_o(op_addr_o),
      .op_abort_o(op_abort_o),
      .op_done_i(op_done_i), .protect_status_low_o(protect_status_low_o),
      .protect_status_mid_o(protect_status_mid_o),
      .protection_scheme_select_o(protection_scheme_select_o));
   fwpr_engine_model engine (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .op_start_i(op_start_o), .op_abort_i(op_abort_o), .op_done_o(op_done_i));
   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One decoded instruction for one cycle; the answer stands in the next cycle.
   task automatic issue(input logic [7:0] c, input logic [23:0] a, input logic [23:0] d,
                        input logic exp);
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b1;
      instr_code_i <= c;
      instr_addr_i <= a;
      instr_data_i <= d;
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b0;
      #1;
      `CHK("answer", {exp, ~exp}, {instr_accept_o, instr_reject_o})
   endtask
   task automatic wren();
      issue(OP_WREN, 24'h000000, 24'h000000, 1'b1);
   endtask
   // Waits, bounded, for the engine to finish and busy to drop.
   task automatic wait_idle();
      int i;
      for (i = 0; i < 100 && protect_status_low_o[BIT_BUSY] !== 1'b0; i++)
      begin
         @(posedge clk_sys_i);
         #1;
      end
      `CHK("busy", 1'b0, protect_status_low_o[BIT_BUSY])
   endtask
   task automatic wrsr(input logic [23:0] d, input logic exp);
      wren();
      issue(OP_WRSR, 24'h000000, d, exp);
      wait_idle();
   endtask
   // Main sequence.
   initial
   begin
      resetn_i = 1'b0;
      reset_pin_n_i = 1'b1;
      supply_low_i = 1'b0;
      write_protect_n_i = 1'b1;
      instr_valid_i = 1'b0;
      instr_code_i = 8'h00;
      instr_addr_i = 24'h000000;
      instr_data_i = 24'h000000;
      repeat (12) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      @(posedge clk_sys_i);
      #1;
      `CHK("status_low", 8'h00, protect_status_low_o)
      `CHK("status_mid", 8'h00, protect_status_mid_o)
      `CHK("scheme", 1'b0, protection_scheme_select_o)
      issue(OP_WREN, 24'h000000, 24'h000000, 1'b0);
      repeat (8) @(posedge clk_sys_i);
      issue(OP_PP, 24'h000000, 24'h000000, 1'b0);
      wren();
      `CHK("wel", 1'b1, protect_status_low_o[BIT_WEL])
      issue(OP_WRDI, 24'h000000, 24'h000000, 1'b1);
      `CHK("wel", 1'b0, protect_status_low_o[BIT_WEL])
      wren();
      issue(OP_PP, 24'h000100, 24'h000000, 1'b1);
      `CHK("start", 1'b1, op_start_o)
      `CHK("busy_wel", 2'b01, protect_status_low_o[1:0])
      `CHK("op_code", OP_PP, op_code_o)
      `CHK("op_addr", 24'h000100, op_addr_o)
      issue(OP_WREN, 24'h000000, 24'h000000, 1'b0);
      issue(OP_RDSR1, 24'h000000, 24'h000000, 1'b1);
      wait_idle();
      wrsr(24'h000004, 1'b1);
      `CHK("status_low", 8'h04, protect_status_low_o)
      wren();
      issue(OP_PP, 24'h3f0000, 24'h000000, 1'b0);
      wren();
      issue(OP_PP, 24'h000000, 24'h000000, 1'b1);
      wait_idle();
      wrsr(24'h004004, 1'b1);
      `CHK("status_mid", 8'h40, protect_status_mid_o)
      wren();
      issue(OP_PP, 24'h000000, 24'h000000, 1'b0);
      wren();
      issue(OP_PP, 24'h3f0000, 24'h000000, 1'b1);
      wait_idle();
      wrsr(24'h000044, 1'b1);
      `CHK("status_low", 8'h44, protect_status_low_o)
      wren();
      issue(OP_PP, 24'h3ff000, 24'h000000, 1'b0);
      wren();
      issue(OP_PP, 24'h3fe000, 24'h000000, 1'b1);
      wait_idle();
      wrsr(24'h040000, 1'b1);
      `CHK("scheme", 1'b1, protection_scheme_select_o)
      wren();
      issue(OP_PP, 24'h000000, 24'h000000, 1'b0);
      wren();
      issue(OP_UNLOCK, 24'h000000, 24'h000000, 1'b1);
      wren();
      issue(OP_PP, 24'h000000, 24'h000000, 1'b1);
      wait_idle();
      wren();
      issue(OP_PP, 24'h010000, 24'h000000, 1'b0);
      issue(OP_UNLOCK, 24'h3ff000, 24'h000000, 1'b1);
      issue(OP_PP, 24'h3fe000, 24'h000000, 1'b0);
      issue(OP_PP, 24'h3ff000, 24'h000000, 1'b1);
      wait_idle();
      wrsr(24'h000080, 1'b1);
      write_protect_n_i <= 1'b0;
      wren();
      issue(OP_WRSR, 24'h000000, 24'h000000, 1'b0);
      write_protect_n_i <= 1'b1;
      wrsr(24'h000000, 1'b1);
      issue(OP_RST_EN, 24'h000000, 24'h000000, 1'b1);
      issue(OP_RST, 24'h000000, 24'h000000, 1'b1);
      `CHK("abort", 1'b1, op_abort_o)
      issue(OP_RDSR1, 24'h000000, 24'h000000, 1'b0);
      repeat (3760) @(posedge clk_sys_i);
      wren();
      issue(OP_RST_EN, 24'h000000, 24'h000000, 1'b1);
      issue(OP_RDSR1, 24'h000000, 24'h000000, 1'b1);
      issue(OP_RST, 24'h000000, 24'h000000, 1'b0);
      `CHK("wel", 1'b1, protect_status_low_o[BIT_WEL])
      issue(OP_PP, 24'h000100, 24'h000000, 1'b1);
      a0 = n_abort;
      reset_pin_n_i <= 1'b0;
      issue(OP_RDSR1, 24'h000000, 24'h000000, 1'b0);
      repeat (130) @(posedge clk_sys_i);
      reset_pin_n_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      #1;
      `CHK("pin_abort", 1'b1, n_abort > a0)
      `CHK("busy_wel", 2'b00, protect_status_low_o[1:0])
      issue(OP_PDOWN, 24'h000000, 24'h000000, 1'b1);
      issue(OP_WREN, 24'h000000, 24'h000000, 1'b0);
      issue(OP_RELEASE, 24'h000000, 24'h000000, 1'b1);
      wrsr(24'h000100, 1'b1);
      `CHK("status_mid", 8'h01, protect_status_mid_o)
      wren();
      issue(OP_WRSR, 24'h000000, 24'h000000, 1'b0);
      wren();
      supply_low_i <= 1'b1;
      issue(OP_RDSR1, 24'h000000, 24'h000000, 1'b0);
      supply_low_i <= 1'b0;
      issue(OP_WREN, 24'h000000, 24'h000000, 1'b0);
      `CHK("status_mid", 8'h00, protect_status_mid_o)
      complete_run();
   end
   // Watchdog well beyond the expected run of about 4300 cycles.
   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      n_errors++;
      complete_run();
   end
endmodule // flash_write_protect_reset_test
